//--- hpb_defs.svh
// constants for the host parallel bus front end
`ifndef HPB_DEFS_SVH
`define HPB_DEFS_SVH
`define HPB_DW 16
`define HPB_SYNC_W 3
`define HPB_SEL_CMD 1'b1
`define HPB_SEL_DATA 1'b0
`define HPB_CFG_16 2'h0
`define HPB_CFG_8 2'h2
`define HPB_REF_HZ 6000000
`define HPB_SYS_HZ 125000000
`define HPB_DIV_W 8
`define HPB_DIV_RST 8'h00
`define HPB_DATA_RST 16'h0000
`define HPB_BYTE_MASK 16'h00ff
`define HPB_IDLE_HI 1'b1
`define HPB_IDLE_LO 1'b0
`define HPB_DIV_STEP 8'h01
`endif

//--- hpb_pkg.sv
// types for the host parallel bus front end
`include "hpb_defs.svh"
package hpb_pkg;
  typedef enum logic [1:0] {hpb_idle, hpb_read, hpb_write} hpb_phase_t;
endpackage : hpb_pkg

//--- hpb_sync.sv
// three-stage pin synchroniser with agreement filter
module hpb_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rst_level,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } hpb_sync_st_t;
  hpb_sync_st_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    // stored relative to the idle level, so reset stays a constant
    st_next.s1 = pin_in ^ rst_level;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a change counts once stages two and three agree
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign level_out = st_reg.lvl ^ rst_level;
endmodule : hpb_sync

//--- hpb_bus_decode.sv
// host parallel bus decode: strobes, address select, data bus and clock out
// How it works
// - multiplexed bus: falling address latch enable captures shared line, 1 command
// - multiplexed read: shared line carries bit 0 of returned data word
// - multiplexed write: shared line level becomes bit 0 of written word
// - separate bus: dedicated select input high means command, low means data
// - low reset input resets everything asynchronously
// - sixteen-bit data bus driven only during reads, sampled during writes
// - clock output frequency comes from a programmable divider setting
// - reference clock is 6 MHz; core logic runs on the system clock
// - config selectors choose 16-bit or 8-bit port; others reserved
`include "hpb_defs.svh"
module hpb_bus_decode
  import hpb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // configuration pins
  input wire logic bus_cfg_sel_lo,
  input wire logic bus_cfg_sel_hi,
  input wire logic mux_mode,
  // host strobes
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic cmd_data_select,
  // shared address/data line
  input wire logic shared_addr_data_line_in,
  output logic shared_addr_data_line_out,
  output logic shared_addr_data_line_oe,
  // data lines 15..0 (bit 0 input ignored on multiplexed writes; bit 0 still driven on reads)
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  // core side
  input wire logic [15:0] rd_data,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic [15:0] wr_data,
  output logic access_is_cmd,
  output logic cfg_reserved,
  output logic cfg_wide,
  // clock output control
  input wire logic [7:0] clk_div,
  output logic prog_clock_out
);
  logic cs_s, rd_s, wr_s, ale_s, a0_s, ad0_s;
  logic [15:0] d_s;
  logic [1:0] cfg;

  // strobes idle high, so no false access follows reset
  hpb_sync u_cs (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rst_level(`HPB_IDLE_HI),
    .pin_in(cs_n),
    .level_out(cs_s)
  );
  hpb_sync u_rd (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rst_level(`HPB_IDLE_HI),
    .pin_in(rd_n),
    .level_out(rd_s)
  );
  hpb_sync u_wr (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rst_level(`HPB_IDLE_HI),
    .pin_in(wr_n),
    .level_out(wr_s)
  );
  hpb_sync u_ale (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rst_level(`HPB_IDLE_LO),
    .pin_in(ale),
    .level_out(ale_s)
  );
  hpb_sync u_a0 (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rst_level(`HPB_IDLE_LO),
    .pin_in(cmd_data_select),
    .level_out(a0_s)
  );
  hpb_sync u_ad0 (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rst_level(`HPB_IDLE_LO),
    .pin_in(shared_addr_data_line_in),
    .level_out(ad0_s)
  );
  hpb_sync u_c0 (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rst_level(`HPB_IDLE_LO),
    .pin_in(bus_cfg_sel_lo),
    .level_out(cfg[0])
  );
  hpb_sync u_c1 (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rst_level(`HPB_IDLE_LO),
    .pin_in(bus_cfg_sel_hi),
    .level_out(cfg[1])
  );

  genvar gi;
  generate
    for (gi = 0; gi < `HPB_DW; gi++) begin : g_dsync
      hpb_sync u_d (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .rst_level(`HPB_IDLE_LO),
        .pin_in(data_in[gi]),
        .level_out(d_s[gi])
      );
    end
  endgenerate

  typedef struct packed {
    hpb_phase_t phase;
    logic ale_d;
    logic wr_d;
    logic rd_d;
    logic addr_mux;
    logic [15:0] wdata;
    logic [15:0] dout;
    logic ad0_out;
    logic rd_pulse;
    logic wr_pulse;
    logic [7:0] div_cnt;
    logic clk_q;
  } hpb_st_t;
  hpb_st_t st_reg, st_next;

  logic wide;
  logic reserved;
  logic is_cmd;
  logic sel;

  always_comb begin
    wide = (cfg == `HPB_CFG_16);
    reserved = (cfg != `HPB_CFG_16) && (cfg != `HPB_CFG_8);
    is_cmd = mux_mode ? st_reg.addr_mux : a0_s;
    sel = !cs_s && !reserved;
    st_next = st_reg;
    st_next.ale_d = ale_s;
    st_next.wr_d = wr_s;
    st_next.rd_d = rd_s;
    st_next.rd_pulse = 1'b0;
    st_next.wr_pulse = 1'b0;
    // address phase capture on falling latch enable
    if (mux_mode && st_reg.ale_d && !ale_s) begin
      st_next.addr_mux = ad0_s;
    end
    case (st_reg.phase)
      hpb_idle: begin
        if (sel && !rd_s) begin
          st_next.phase = hpb_read;
          st_next.rd_pulse = 1'b1;
          st_next.dout = wide ? rd_data : (rd_data & `HPB_BYTE_MASK);
          st_next.ad0_out = rd_data[0];
        end else if (sel && !wr_s) begin
          st_next.phase = hpb_write;
        end
      end
      hpb_read: begin
        if (rd_s || cs_s) begin
          st_next.phase = hpb_idle;
        end
      end
      hpb_write: begin
        // data taken on the rising write strobe
        if (wr_s && !st_reg.wr_d) begin
          st_next.phase = hpb_idle;
          st_next.wr_pulse = 1'b1;
          st_next.wdata = wide ? d_s : (d_s & `HPB_BYTE_MASK);
          if (mux_mode) begin
            st_next.wdata[0] = ad0_s;
          end
        end else if (cs_s) begin
          st_next.phase = hpb_idle;
        end
      end
      default: begin
        st_next.phase = hpb_idle;
      end
    endcase
    // programmable clock divider off the system clock
    if (st_reg.div_cnt >= clk_div) begin
      st_next.div_cnt = `HPB_DIV_RST;
      st_next.clk_q = !st_reg.clk_q;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + `HPB_DIV_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_out = st_reg.dout;
  assign data_oe = (st_reg.phase == hpb_read);
  assign shared_addr_data_line_out = st_reg.ad0_out;
  assign shared_addr_data_line_oe = (st_reg.phase == hpb_read) && mux_mode;
  assign wr_data = st_reg.wdata;
  assign rd_strobe = st_reg.rd_pulse;
  assign wr_strobe = st_reg.wr_pulse;
  assign access_is_cmd = is_cmd;
  assign cfg_reserved = reserved;
  assign cfg_wide = wide;
  assign prog_clock_out = st_reg.clk_q;
endmodule : hpb_bus_decode

//--- hpb_bus_decode_monitor.sv
// port assertions for the bus decode
module hpb_mon (
  input wire logic sys_clk, resetn, mux_mode, cmd_data_select, bus_cfg_sel_lo, bus_cfg_sel_hi,
  input wire logic cs_n, data_oe, shared_addr_data_line_oe, rd_strobe, wr_strobe,
  input wire logic access_is_cmd, cfg_reserved, cfg_wide, prog_clock_out,
  input wire logic [15:0] wr_data,
  input wire logic [7:0] clk_div
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  share_oe_a: assert property (shared_addr_data_line_oe |-> mux_mode && data_oe)
    else $error("shared oe");
  idle_quiet_a: assert property (cs_n[*8] |-> !data_oe && !rd_strobe && !wr_strobe)
    else $error("idle bus");
  resv_block_a: assert property (cfg_reserved[*4] |-> !rd_strobe && !wr_strobe)
    else $error("reserved access");
  resv_dec_a: assert property (bus_cfg_sel_lo[*8] |-> cfg_reserved && !cfg_wide)
    else $error("reserved decode");
  wide_dec_a: assert property ((!bus_cfg_sel_lo && !bus_cfg_sel_hi)[*8] |-> cfg_wide)
    else $error("wide decode");
  narrow_wr_a: assert property (wr_strobe && !cfg_wide |-> wr_data[15:8] == 8'h00)
    else $error("narrow write");
  sep_cmd_a: assert property ((rd_strobe || wr_strobe) && !mux_mode |->
    access_is_cmd == cmd_data_select) else $error("select");
  div_clk_a: assert property ($changed(prog_clock_out) && clk_div == 8'h01 &&
    $past(clk_div) == 8'h01 |=> $stable(prog_clock_out) ##1 $changed(prog_clock_out))
    else $error("clock out");
endmodule : hpb_mon
bind hpb_bus_decode hpb_mon mon (.*);

//--- hpb_host.sv
// host bus master model
module hpb_host (
  input wire logic sys_clk, mux_mode, data_oe, shared_addr_data_line_oe, shared_addr_data_line_out,
  input wire logic [15:0] data_out,
  output logic cs_n, rd_n, wr_n, ale, cmd_data_select, shared_addr_data_line_in,
  output logic [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hd;
  logic ha;
  // released lines show the inverse of the last level
  assign data_in = data_oe ? data_out : hd;
  assign shared_addr_data_line_in = shared_addr_data_line_oe ? shared_addr_data_line_out : ha;
  initial {cs_n, rd_n, wr_n, ale, cmd_data_select, hd, ha} = {5'h1c, 17'h0};
  task automatic acc(input logic wr, cmd, input logic [15:0] d, output logic [15:0] q);
    ale <= mux_mode;
    ha <= cmd;
    cmd_data_select <= !mux_mode && cmd;
    repeat (6) @(posedge sys_clk);
    ale <= 1'b0;
    repeat (6) @(posedge sys_clk);
    cs_n <= 1'b0;
    rd_n <= wr;
    wr_n <= !wr;
    hd <= wr ? d : ~hd;
    ha <= wr ? d[0] : ~ha;
    repeat (8) @(posedge sys_clk);
    q = {data_in[15:1], mux_mode ? shared_addr_data_line_in : data_in[0]};
    {rd_n, wr_n} <= 2'h3;
    repeat (8) @(posedge sys_clk);
    {cs_n, cmd_data_select} <= 2'h2;
    hd <= ~hd;
    ha <= ~ha;
    repeat (8) @(posedge sys_clk);
  endtask : acc
endmodule : hpb_host

//--- hpb_bus_decode_bench.sv
// random bus accesses against the decode
module hpb_bus_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, bus_cfg_sel_lo, bus_cfg_sel_hi, mux_mode, cs_n, rd_n, wr_n, ale;
  logic cmd_data_select, shared_addr_data_line_in, shared_addr_data_line_out;
  logic shared_addr_data_line_oe, data_oe, rd_strobe, wr_strobe, access_is_cmd;
  logic cfg_reserved, cfg_wide, prog_clock_out, w, c, cmd_seen;
  logic [15:0] data_in, data_out, rd_data, wr_data, d, q, cap;
  logic [7:0] clk_div;
  int bad_count, checked, seen, n;
  hpb_bus_decode DUT (.*);
  hpb_host host (.*);
  always @(posedge sys_clk) if (rd_strobe || wr_strobe) begin
    seen <= seen + 1;
    cap <= wr_data;
    cmd_seen <= access_is_cmd;
  end
  task chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  function logic [15:0] ex(input logic [15:0] v);
    return bus_cfg_sel_hi ? v & 16'h00ff : v;
  endfunction : ex
  task stop_test;
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #100us;
    bad_count++;
    stop_test;
  end
  initial begin
    {resetn, bus_cfg_sel_lo, bus_cfg_sel_hi, mux_mode, rd_data, seen} = 0;
    clk_div = 8'h01;
    void'($urandom(88291));
    repeat (10) @(posedge sys_clk);
    chk(16'({data_oe, prog_clock_out, rd_strobe}), 16'h0);
    resetn <= 1'b1;
    bus_cfg_sel_lo <= 1'b1;
    repeat (8) @(posedge sys_clk);
    n = seen;
    host.acc(1'b1, 1'b0, 16'h1234, q);
    chk(16'(seen - n), 16'h0);
    resetn <= 1'b0;
    @(negedge sys_clk);
    chk(16'({data_oe, prog_clock_out}), 16'h0);
    @(posedge sys_clk);
    resetn <= 1'b1;
    bus_cfg_sel_lo <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      mux_mode <= i[0];
      bus_cfg_sel_hi <= i[1];
      rd_data <= i < 4 ? 16'hffff : 16'($urandom);
      w = i[2] ^ 1'($urandom);
      c = 1'($urandom);
      d = i < 4 ? 16'hffff : 16'($urandom);
      repeat (8) @(posedge sys_clk);
      n = seen;
      host.acc(w, c, d, q);
      chk(16'(seen - n), 16'h1);
      chk(16'(cmd_seen), 16'(c));
      chk(w ? cap : q, ex(w ? d : rd_data));
    end
    stop_test;
  end
endmodule : hpb_bus_decode_bench
